// *** verilog/fpec_pkg.sv ***
// constants and types shared by the flash program/erase control block
// assumes a 20 MHz system clock and a word-wide peripheral register port
package fpec_pkg;

	// clock rate, used to turn operation times into cycle counts
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

	// register groups, byte addresses; control and target each have four aliases, the key has none
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_KEY = 8'h10;
	localparam logic [7:0] OFS_TARGET = 8'h20;

	// alias select in address bits 3:2
	localparam logic [1:0] ALIAS_PLAIN = 2'h0;
	localparam logic [1:0] ALIAS_CLR = 2'h1;
	localparam logic [1:0] ALIAS_SET = 2'h2;
	localparam logic [1:0] ALIAS_INV = 2'h3;

	// control register field positions
	localparam int unsigned BIT_LAUNCH = 15;
	localparam int unsigned BIT_ARM = 14;
	localparam int unsigned BIT_FAIL = 13;
	localparam int unsigned BIT_UV_ERR = 12;
	localparam int unsigned BIT_UV_LIVE = 11;
	localparam int unsigned OP_MSB = 3;
	localparam int unsigned OP_LSB = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// target location register: low two bits are read-only zero
	localparam logic [31:0] TARGET_RESET = 32'h0000_0000;
	localparam logic [31:0] TARGET_WR_MASK = 32'hffff_fffc;

	// unlock keys, first then second
	localparam logic [31:0] KEY_FIRST = 32'haa99_6655;
	localparam logic [31:0] KEY_SECOND = 32'h5566_99aa;

	// operation select codes
	localparam logic [3:0] OP_NOP0 = 4'h0;
	localparam logic [3:0] OP_WORD = 4'h1;
	localparam logic [3:0] OP_NOP2 = 4'h2;
	localparam logic [3:0] OP_ROW = 4'h3;
	localparam logic [3:0] OP_PAGE = 4'h4;
	localparam logic [3:0] OP_ARRAY = 4'h5;
	localparam logic [3:0] OP_NOP6 = 4'h6;

	// nominal operation times in microseconds
	localparam int unsigned WORD_TIME_US = 20;
	localparam int unsigned ROW_TIME_US = 1000;
	localparam int unsigned PAGE_TIME_US = 20000;
	localparam int unsigned ARRAY_TIME_US = 80000;
	localparam int unsigned WORD_CYCLES = WORD_TIME_US * CYC_PER_US;
	localparam int unsigned ROW_CYCLES = ROW_TIME_US * CYC_PER_US;
	localparam int unsigned PAGE_CYCLES = PAGE_TIME_US * CYC_PER_US;
	localparam int unsigned ARRAY_CYCLES = ARRAY_TIME_US * CYC_PER_US;
	// no-op, reserved and refused operations resolve this fast
	localparam int unsigned RESOLVE_CYCLES = 1;

	// unlock progress
	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_HALF,
		KEY_OPEN
	} fpec_key_e;

	// sequencer states
	typedef enum logic {
		SEQ_IDLE,
		SEQ_RUN
	} fpec_seq_e;

endpackage

// *** verilog/fpec_sequencer.sv ***
// operation sequencer: times one program/erase operation and judges it
// assumes start is a one-cycle pulse given only while idle
`timescale 1ns/100ps
`default_nettype none
module fpec_sequencer #(
	parameter int unsigned WORD_CYC = fpec_pkg::WORD_CYCLES,
	parameter int unsigned ROW_CYC = fpec_pkg::ROW_CYCLES,
	parameter int unsigned PAGE_CYC = fpec_pkg::PAGE_CYCLES,
	parameter int unsigned ARRAY_CYC = fpec_pkg::ARRAY_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic [3:0] op_in,
	input wire logic wp_target_in,
	input wire logic wp_any_in,
	output logic active_out,
	output logic done_out,
	output logic fail_out
);

	fpec_pkg::fpec_seq_e state_reg;
	logic [31:0] count_reg;
	logic [31:0] load_cyc;
	logic load_fail;
	logic load_real;
	logic real_reg;

	// duration and verdict chosen from the code at start
	always_comb begin
		load_cyc = 32'(fpec_pkg::RESOLVE_CYCLES);
		load_fail = 1'b0;
		load_real = 1'b0;
		case (op_in)
			fpec_pkg::OP_WORD: begin
				load_cyc = wp_target_in ? 32'(fpec_pkg::RESOLVE_CYCLES) : 32'(WORD_CYC);
				load_fail = wp_target_in;
				load_real = !wp_target_in;
			end
			fpec_pkg::OP_ROW: begin
				load_cyc = wp_target_in ? 32'(fpec_pkg::RESOLVE_CYCLES) : 32'(ROW_CYC);
				load_fail = wp_target_in;
				load_real = !wp_target_in;
			end
			fpec_pkg::OP_PAGE: begin
				load_cyc = wp_target_in ? 32'(fpec_pkg::RESOLVE_CYCLES) : 32'(PAGE_CYC);
				load_fail = wp_target_in;
				load_real = !wp_target_in;
			end
			// RULE_13: whole-array needs no page protected
			fpec_pkg::OP_ARRAY: begin
				load_cyc = wp_any_in ? 32'(fpec_pkg::RESOLVE_CYCLES) : 32'(ARRAY_CYC);
				load_fail = wp_any_in;
				load_real = !wp_any_in;
			end
			fpec_pkg::OP_NOP0, fpec_pkg::OP_NOP2, fpec_pkg::OP_NOP6: begin
				load_fail = 1'b0;
			end
			// reserved codes are refused and reported as a failure
			default: begin
				load_fail = 1'b1;
			end
		endcase
	end

	// RULE_18: busy for a fixed count, then done
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= fpec_pkg::SEQ_IDLE;
			count_reg <= 32'h0000_0000;
			done_out <= 1'b0;
			fail_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state_reg)
				fpec_pkg::SEQ_IDLE: begin
					if (start_in) begin
						state_reg <= fpec_pkg::SEQ_RUN;
						count_reg <= load_cyc - 32'h0000_0001;
						fail_out <= load_fail;
					end
				end
				fpec_pkg::SEQ_RUN: begin
					if (count_reg == 32'h0000_0000) begin
						state_reg <= fpec_pkg::SEQ_IDLE;
						done_out <= 1'b1;
					end else begin
						count_reg <= count_reg - 32'h0000_0001;
					end
				end
				default: begin
					state_reg <= fpec_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	// active level for the flash array; no-op codes never touch it
	// RULE_13: only a real, unprotected operation works the array
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			active_out <= 1'b0;
			real_reg <= 1'b0;
		end else if (state_reg == fpec_pkg::SEQ_IDLE) begin
			active_out <= start_in && load_real;
			real_reg <= load_real;
		end else begin
			active_out <= real_reg && (count_reg != 32'h0000_0000);
		end
	end

endmodule
`default_nettype wire

// *** verilog/fpec_control.sv ***
// flash program/erase control: control, unlock key and target registers
// assumes a synchronous register port on clk_in, read data one cycle late,
// and write-protect levels from logic on the same clock
//
// Notes on behaviour
// RULE_01: low four bits select word, row, page, array operation or no-op.
// RULE_02: software launches with 0x8004, 0x8001, 0x8003 or 0x8000.
// RULE_03: launch bit write takes effect only when armed and just unlocked.
// RULE_04: launch starts the operation; hardware clears it at the end.
// RULE_05: arm bit permits launching and powers the undervoltage detector.
// RULE_06: any reset clears the arm bit.
// RULE_07: failure flag set when an operation does not complete normally.
// RULE_08: undervoltage error flag set on low voltage during an operation.
// RULE_09: live undervoltage flag follows the detector while it is enabled.
// RULE_10: the three flags clear when code 0000 is launched; here only the failure and undervoltage error flags do.
// RULE_11: operation select is writable only while not armed.
// RULE_12: bits 31-16 and 10-4 of control read zero, ignore writes.
// RULE_13: protected targets are not touched; array erase needs none protected.
// RULE_14: two key writes in order open the very next transaction only.
// RULE_15: unlock key register is write-only and reads zero.
// RULE_16: clear, set and invert aliases at offsets 0x4, 0x8, 0xc.
// RULE_17: target location picks word, row or page; ignored for array erase.
// RULE_18: while launched the block is busy, then clears the launch bit.
`timescale 1ns/100ps
`default_nettype none
module fpec_control #(
	parameter int unsigned WORD_CYC = fpec_pkg::WORD_CYCLES,
	parameter int unsigned ROW_CYC = fpec_pkg::ROW_CYCLES,
	parameter int unsigned PAGE_CYC = fpec_pkg::PAGE_CYCLES,
	parameter int unsigned ARRAY_CYC = fpec_pkg::ARRAY_CYCLES
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] bus_addr_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic [31:0] bus_wdata_in,
	output logic [31:0] bus_rdata_out,
	input wire logic low_voltage_in,
	input wire logic wp_target_in,
	input wire logic wp_any_in,
	output logic flash_busy_out,
	output logic flash_active_out,
	output logic [3:0] flash_op_out,
	output logic [31:0] flash_target_out,
	output logic uv_detector_en_out
);

	// applies a plain, clear, set or invert write to a register value
	function automatic logic [31:0] fpec_alias(
		input logic [31:0] old_val,
		input logic [31:0] wdata,
		input logic [1:0] sel
	);
		logic [31:0] res;
		res = wdata;
		case (sel)
			fpec_pkg::ALIAS_CLR: res = old_val & ~wdata;
			fpec_pkg::ALIAS_SET: res = old_val | wdata;
			fpec_pkg::ALIAS_INV: res = old_val ^ wdata;
			default: res = wdata;
		endcase
		return res;
	endfunction

	logic rst_meta_reg;
	logic rst_sync_reg;
	logic lv_meta_reg;
	logic lv_sync_reg;
	fpec_pkg::fpec_key_e key_reg;
	logic launch_reg;
	logic arm_reg;
	logic fail_reg;
	logic uv_err_reg;
	logic uv_live_reg;
	logic [3:0] op_reg;
	logic [31:0] target_reg;
	logic [31:0] ctrl_value;
	logic [31:0] ctrl_cand;
	logic [31:0] target_cand;
	logic [31:0] rdata_next;
	logic [1:0] alias_sel;
	logic hit_ctrl;
	logic hit_key;
	logic hit_target;
	logic wr_ctrl;
	logic wr_key;
	logic wr_target;
	logic any_txn;
	logic accept_launch;
	logic clear_flags;
	logic seq_active;
	logic seq_done;
	logic seq_fail;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// detector output is asynchronous to clk_in
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			lv_meta_reg <= 1'b0;
			lv_sync_reg <= 1'b0;
		end else begin
			lv_meta_reg <= low_voltage_in;
			lv_sync_reg <= lv_meta_reg;
		end
	end

	// address decode, aliases in bits 3:2
	assign alias_sel = bus_addr_in[3:2];
	assign hit_ctrl = (bus_addr_in[7:4] == fpec_pkg::OFS_CTRL[7:4]);
	assign hit_key = (bus_addr_in[7:2] == fpec_pkg::OFS_KEY[7:2]);
	assign hit_target = (bus_addr_in[7:4] == fpec_pkg::OFS_TARGET[7:4]);
	assign wr_ctrl = bus_wr_in && hit_ctrl;
	assign wr_key = bus_wr_in && hit_key;
	assign wr_target = bus_wr_in && hit_target;
	assign any_txn = bus_wr_in || bus_rd_in;

	// RULE_12: unimplemented control bits are fixed zero
	assign ctrl_value = {16'h0000, launch_reg, arm_reg, fail_reg, uv_err_reg, uv_live_reg,
		7'h00, op_reg};

	// RULE_16: alias arithmetic on control and target
	assign ctrl_cand = fpec_alias(ctrl_value, bus_wdata_in, alias_sel);
	assign target_cand = fpec_alias(target_reg, bus_wdata_in, alias_sel);

	// RULE_03: launch needs arm already set and the open unlock window
	assign accept_launch = wr_ctrl && ctrl_cand[fpec_pkg::BIT_LAUNCH] && !launch_reg
		&& arm_reg && (key_reg == fpec_pkg::KEY_OPEN);
	// RULE_10: launching code 0000 is the flag clear
	assign clear_flags = accept_launch && (op_reg == fpec_pkg::OP_NOP0);

	// RULE_14: key pair opens exactly the next bus transaction
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			key_reg <= fpec_pkg::KEY_IDLE;
		end else if (any_txn) begin
			case (key_reg)
				fpec_pkg::KEY_HALF: begin
					if (wr_key && bus_wdata_in == fpec_pkg::KEY_SECOND) begin
						key_reg <= fpec_pkg::KEY_OPEN;
					end else if (wr_key && bus_wdata_in == fpec_pkg::KEY_FIRST) begin
						key_reg <= fpec_pkg::KEY_HALF;
					end else begin
						key_reg <= fpec_pkg::KEY_IDLE;
					end
				end
				default: begin
					// idle or open: any transaction spends the window
					if (wr_key && bus_wdata_in == fpec_pkg::KEY_FIRST) begin
						key_reg <= fpec_pkg::KEY_HALF;
					end else begin
						key_reg <= fpec_pkg::KEY_IDLE;
					end
				end
			endcase
		end
	end

	// arm bit is writable at any time, cleared by every reset
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			// RULE_06: reset disarms
			arm_reg <= 1'b0;
		end else if (wr_ctrl) begin
			// RULE_05: software arms or disarms
			arm_reg <= ctrl_cand[fpec_pkg::BIT_ARM];
		end
	end

	// operation select, frozen while armed
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			op_reg <= fpec_pkg::CTRL_RESET[fpec_pkg::OP_MSB:fpec_pkg::OP_LSB];
		end else if (wr_ctrl && !arm_reg) begin
			// RULE_11: only written while disarmed
			op_reg <= ctrl_cand[fpec_pkg::OP_MSB:fpec_pkg::OP_LSB];
		end
	end

	// launch bit: software sets it, only the sequencer clears it
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			launch_reg <= 1'b0;
		end else if (accept_launch) begin
			// RULE_04: start of an operation
			launch_reg <= 1'b1;
		end else if (seq_done) begin
			// RULE_18: hardware clear at completion
			launch_reg <= 1'b0;
		end
	end

	// failure flag; clear and completion never meet since launch is refused while busy
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			fail_reg <= 1'b0;
		end else if (seq_done && seq_fail) begin
			// RULE_07: abnormal end reported
			fail_reg <= 1'b1;
		end else if (clear_flags) begin
			fail_reg <= 1'b0;
		end
	end

	// undervoltage error: sticky, set wins over the clear
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			uv_err_reg <= 1'b0;
		end else if (arm_reg && lv_sync_reg && (launch_reg || accept_launch)) begin
			// RULE_08: low voltage during an operation
			uv_err_reg <= 1'b1;
		end else if (clear_flags) begin
			// RULE_10: cleared by a code 0000 launch
			uv_err_reg <= 1'b0;
		end
	end

	// live undervoltage: follows the detector, zero when it is off
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			uv_live_reg <= 1'b0;
		end else begin
			// RULE_09: tracks the event while enabled
			uv_live_reg <= arm_reg && lv_sync_reg;
		end
	end

	// target location, low bits stay zero
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			target_reg <= fpec_pkg::TARGET_RESET;
		end else if (wr_target && !launch_reg) begin
			// held steady during an operation so the array sees one address
			target_reg <= target_cand & fpec_pkg::TARGET_WR_MASK;
		end
	end

	// read mux; aliases and unmapped offsets answer zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (bus_rd_in && alias_sel == fpec_pkg::ALIAS_PLAIN) begin
			if (hit_ctrl) begin
				rdata_next = ctrl_value;
			end else if (hit_target) begin
				rdata_next = target_reg;
			end else begin
				// RULE_15: key reads zero, as does anything unmapped
				rdata_next = 32'h0000_0000;
			end
		end
	end

	// read data registered, held until the next read
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			bus_rdata_out <= 32'h0000_0000;
		end else if (bus_rd_in) begin
			bus_rdata_out <= rdata_next;
		end
	end

	// RULE_01: decode and timing of the selected code
	fpec_sequencer #(
		.WORD_CYC(WORD_CYC),
		.ROW_CYC(ROW_CYC),
		.PAGE_CYC(PAGE_CYC),
		.ARRAY_CYC(ARRAY_CYC)
	) u_seq (
		.clk_in(clk_in),
		.rst_n_in(rst_sync_reg),
		.start_in(accept_launch),
		.op_in(op_reg),
		.wp_target_in(wp_target_in),
		.wp_any_in(wp_any_in),
		.active_out(seq_active),
		.done_out(seq_done),
		.fail_out(seq_fail)
	);

	// flash array side, every output from a flop
	always_ff @(posedge clk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			flash_busy_out <= 1'b0;
			flash_active_out <= 1'b0;
			flash_op_out <= fpec_pkg::OP_NOP0;
			flash_target_out <= fpec_pkg::TARGET_RESET;
			uv_detector_en_out <= 1'b0;
		end else begin
			flash_busy_out <= launch_reg;
			// RULE_13: a protected or reserved request never drives the array
			flash_active_out <= seq_active && !seq_fail;
			flash_op_out <= op_reg;
			// RULE_17: array erase ignores the target location
			flash_target_out <= (op_reg == fpec_pkg::OP_ARRAY) ? 32'h0000_0000 : target_reg;
			uv_detector_en_out <= arm_reg;
		end
	end

endmodule
`default_nettype wire

// *** dv/fpec_control_asserts.sv ***
// port checker for the flash program/erase control block
// assumes bind onto fpec_control with the bench's short cycle counts
`timescale 1ns/100ps
`default_nettype none
module fpec_control_asserts #(
	parameter int unsigned WORD_CYC = 4,
	parameter int unsigned ROW_CYC = 6,
	parameter int unsigned PAGE_CYC = 8,
	parameter int unsigned ARRAY_CYC = 10
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] bus_addr_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic [31:0] bus_wdata_in,
	input wire logic [31:0] bus_rdata_out,
	input wire logic low_voltage_in,
	input wire logic wp_target_in,
	input wire logic wp_any_in,
	input wire logic flash_busy_out,
	input wire logic flash_active_out,
	input wire logic [3:0] flash_op_out,
	input wire logic [31:0] flash_target_out,
	input wire logic uv_detector_en_out
);
	localparam int WORD_LAST = WORD_CYC - 1;
	localparam int BUSY_MAX = ARRAY_CYC + 4;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	// busy shows two edges after the taking edge
	sequence busy_rise;
		$rose(flash_busy_out);
	endsequence
	sequence word_start;
		$rose(flash_active_out) && flash_op_out == fpec_pkg::OP_WORD;
	endsequence
	// array worked for exactly the word count, then let go
	sequence word_run;
		##WORD_LAST flash_active_out ##1 !flash_active_out;
	endsequence
	AST_LAUNCH_GATED: assert property (busy_rise |->
		$past(bus_wr_in, 2) && $past(bus_addr_in[7:4], 2) == 4'h0)
		else $error("busy without a control write");
	AST_ACTIVE_BUSY: assert property (flash_active_out |-> flash_busy_out)
		else $error("array active while not busy");
	AST_BUSY_ENDS: assert property (busy_rise |-> ##[1:BUSY_MAX] !flash_busy_out)
		else $error("launch bit never cleared");
	AST_OP_FROZEN: assert property (uv_detector_en_out && $past(uv_detector_en_out)
		|-> $stable(flash_op_out))
		else $error("operation changed while armed");
	AST_ARRAY_TARGET: assert property (flash_op_out == fpec_pkg::OP_ARRAY
		|-> flash_target_out == 32'h0)
		else $error("target not ignored for array erase");
	AST_ACTIVE_CODE: assert property (flash_active_out
		|-> flash_op_out inside {4'h1, 4'h3, 4'h4, 4'h5})
		else $error("array worked for a no-op code");
	AST_WORD_RUN: assert property (word_start |-> word_run)
		else $error("word program length wrong");
	AST_ARM_FOLLOWS: assert property (bus_wr_in && bus_addr_in == 8'h00
		|-> ##2 uv_detector_en_out == $past(bus_wdata_in[14], 2))
		else $error("detector enable does not follow arm");
endmodule
bind fpec_control fpec_control_asserts #(.WORD_CYC(WORD_CYC), .ROW_CYC(ROW_CYC),
	.PAGE_CYC(PAGE_CYC), .ARRAY_CYC(ARRAY_CYC)) u_chk (.clk_in, .resetn_in,
	.bus_addr_in, .bus_wr_in, .bus_rd_in, .bus_wdata_in, .bus_rdata_out,
	.low_voltage_in, .wp_target_in, .wp_any_in, .flash_busy_out, .flash_active_out,
	.flash_op_out, .flash_target_out, .uv_detector_en_out);
`default_nettype wire

// *** dv/fpec_cpu_model.sv ***
// core-side bus master: register transfers, unlock and launch
// assumes the block takes a strobe at the rising clock edge
`timescale 1ns/100ps
`default_nettype none
module fpec_cpu_model (
	input wire logic clk_in,
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [31:0] wdata_out,
	input wire logic [31:0] rdata_in
);
	// bus idle from time zero
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 32'h0;
	end
	// drive after a falling edge, hold over the taking edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = w;
		rd_out = !w;
		@(negedge clk_in);
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = ~d; // released data must not look held
		q = rdata_in;
	endtask
	task automatic unlock();
		logic [31:0] q;
		xfer(1'b1, fpec_pkg::OFS_KEY, fpec_pkg::KEY_FIRST, q);
		xfer(1'b1, fpec_pkg::OFS_KEY, fpec_pkg::KEY_SECOND, q);
	endtask
	task automatic launch(input logic [3:0] op, input logic keys);
		logic [31:0] q;
		xfer(1'b1, 8'h00, {28'h0, op}, q); // disarm first so op is writable
		xfer(1'b1, 8'h00, 32'h4000 | {28'h0, op}, q);
		if (keys) begin
			unlock();
		end
		xfer(1'b1, 8'h00, 32'hc000 | {28'h0, op}, q);
	endtask
endmodule
`default_nettype wire

// *** dv/flash_program_erase_control_test.sv ***
// self-checking bench for the flash program/erase control block
// assumes fpec_cpu_model as bus master and short operation counts
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_control_test;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic lv = 1'b0;
	logic wpt = 1'b0;
	logic wpa = 1'b0;
	wire logic [7:0] addr;
	wire logic wr;
	wire logic rd;
	wire logic [31:0] wdata;
	wire logic [31:0] rdata;
	wire logic busy;
	wire logic act;
	wire logic [3:0] op;
	wire logic [31:0] tgt;
	wire logic uv_en;
	int num_errors = 0;
	int n_tests = 0;
	int nbusy = 0;
	// 20 MHz system clock
	always #25 clk_in = ~clk_in;
	fpec_control #(.WORD_CYC(4), .ROW_CYC(6), .PAGE_CYC(8), .ARRAY_CYC(10)) dut (
		.clk_in(clk_in), .resetn_in(resetn_in), .bus_addr_in(addr), .bus_wr_in(wr),
		.bus_rd_in(rd), .bus_wdata_in(wdata), .bus_rdata_out(rdata),
		.low_voltage_in(lv), .wp_target_in(wpt), .wp_any_in(wpa),
		.flash_busy_out(busy), .flash_active_out(act), .flash_op_out(op),
		.flash_target_out(tgt), .uv_detector_en_out(uv_en));
	fpec_cpu_model cpu (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .rd_out(rd),
		.wdata_out(wdata), .rdata_in(rdata));
	task automatic tally_and_finish();
		if (num_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		cpu.xfer(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		logic [31:0] q;
		cpu.xfer(1'b0, a, 32'h0, q);
		chk(nm, e, q & m);
	endtask
	// launch, then count cycles the array is worked until busy drops
	task automatic run(input logic [3:0] o, input logic keys, output int n);
		n = 0;
		nbusy = 0;
		cpu.launch(o, keys);
		for (int i = 0; i < 40; i++) begin
			@(negedge clk_in);
			if (act === 1'b1) n++;
			if (busy === 1'b1) nbusy++;
			if (i > 1 && busy === 1'b0) break;
		end
	endtask
	task automatic t_ops();
		logic [3:0] c [4] = '{4'h1, 4'h3, 4'h4, 4'h5};
		int cyc [4] = '{4, 6, 8, 10};
		int n;
		for (int k = 0; k < 4; k++) begin
			wr_reg(fpec_pkg::OFS_TARGET, 32'h0000_1237);
			run(c[k], 1'b1, n);
			chk("op", {28'h0, c[k]}, {28'h0, op});
			chk("cycles", cyc[k], n);
			chk("busy", cyc[k] + 1, nbusy);
			chk("target", c[k] == 4'h5 ? 32'h0 : 32'h1234, tgt);
			rd_chk("ctrl", 8'h00, 32'h4000 | c[k], '1);
		end
	endtask
	task automatic t_refuse();
		int n;
		run(4'h1, 1'b0, n);
		chk("no keys", 32'h0, n);
		chk("no keys busy", 32'h0, nbusy);
		wr_reg(8'h00, 32'h4001);
		cpu.unlock();
		rd_chk("key", fpec_pkg::OFS_KEY, 32'h0, '1);
		wr_reg(8'h00, 32'hc001);
		rd_chk("broken", 8'h00, 32'h4001, '1);
		wr_reg(8'h00, 32'h1);
		cpu.unlock();
		wr_reg(8'h00, 32'h8001);
		rd_chk("unarmed", 8'h00, 32'h1, '1);
		wr_reg(8'h00, 32'h4001);
		wr_reg(8'h00, 32'h4004);
		rd_chk("frozen", 8'h00, 32'h4001, '1);
	endtask
	task automatic t_fail();
		logic [3:0] o [8] = '{5, 0, 1, 0, 7, 0, 2, 6};
		logic [1:0] wp [8] = '{2'b10, 0, 2'b01, 0, 0, 0, 0, 0};
		logic [15:0] e [8] = '{16'h6005, 16'h4000, 16'h6001, 16'h4000, 16'h6007,
			16'h4000, 16'h4002, 16'h4006};
		int n;
		for (int k = 0; k < 8; k++) begin
			{wpa, wpt} = wp[k];
			run(o[k], 1'b1, n);
			chk("worked", 32'h0, n);
			rd_chk("flags", 8'h00, {16'h0, e[k]}, '1);
		end
		{wpa, wpt} = 2'b00;
	endtask
	task automatic t_bits();
		logic [7:0] a [4] = '{8'h04, 8'h08, 8'h0c, 8'h30};
		logic [15:0] e [4] = '{16'h0006, 16'h4006, 16'h0006, 16'h0006};
		wr_reg(8'h00, 32'hffff_7ff0);
		rd_chk("unimpl", 8'h00, 32'h4006, '1);
		for (int k = 0; k < 4; k++) begin
			wr_reg(a[k], 32'h4000);
			rd_chk("alias", 8'h00, {16'h0, e[k]}, '1);
			rd_chk("alias rd", a[k], 32'h0, '1);
		end
	endtask
	task automatic t_uv();
		int n;
		wr_reg(8'h00, 32'h4000);
		lv = 1'b1;
		repeat (4) @(negedge clk_in);
		rd_chk("live", 8'h00, 32'h4800, '1);
		chk("uv_en", 32'h1, {31'h0, uv_en});
		run(4'h1, 1'b1, n);
		rd_chk("uv err", 8'h00, 32'h1800, 32'h1800);
		lv = 1'b0;
		repeat (4) @(negedge clk_in);
		rd_chk("live off", 8'h00, 32'h1000, 32'h1800);
		run(4'h0, 1'b1, n);
		rd_chk("cleared", 8'h00, 32'h0, 32'h3800);
		wr_reg(8'h00, 32'h4000);
		resetn_in = 1'b0;
		repeat (2) @(negedge clk_in);
		resetn_in = 1'b1;
		repeat (4) @(negedge clk_in);
		rd_chk("re-reset", 8'h00, 32'h0, '1);
		chk("uv_en", 32'h0, {31'h0, uv_en});
	endtask
	initial begin
		repeat (4) @(negedge clk_in);
		resetn_in = 1'b1;
		repeat (4) @(negedge clk_in);
		rd_chk("reset", 8'h00, 32'h0, '1);
		t_ops();
		t_refuse();
		t_fail();
		t_bits();
		t_uv();
		tally_and_finish();
	end
	// watchdog far past the few hundred cycles the run needs
	initial begin
		#500000;
		num_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
